// file: logic/raeu_pkg.sv
// Constants and types shared by the reset and address error unit
package raeu_pkg;

    localparam int          SYNC_STAGES  = 3;
    localparam int          N_MAST       = 3;
    localparam logic [31:0] VBASE_RST    = 32'h0000_0000;
    localparam logic [3:0]  MASK_RST     = 4'hF;
    localparam logic [31:0] VEC_SCALE    = 32'h0000_0004;
    localparam logic [31:0] STACK_STEP   = 32'h0000_0004;
    localparam logic [7:0]  VEC_POR_PC   = 8'h00;
    localparam logic [7:0]  VEC_POR_SP   = 8'h01;
    localparam logic [7:0]  VEC_MAN_PC   = 8'h02;
    localparam logic [7:0]  VEC_MAN_SP   = 8'h03;
    localparam logic [7:0]  VEC_CPU_AE   = 8'h09;
    localparam logic [7:0]  VEC_DMA_AE   = 8'h0A;
    localparam logic [23:0] PER_PG_00_LO = 24'hFFFF00;
    localparam logic [23:0] PER_PG_00_HI = 24'hFFFFF0;
    localparam logic [23:0] PER_PG_FC    = 24'hFFFFFC;
    localparam logic [23:0] PER_PG_FE    = 24'hFFFFFE;
    localparam logic [23:0] PER_PG_FF    = 24'hFFFFFF;
    localparam logic [7:0]  OFS_VBASE    = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_DMA_ERR  = 8'h08;
    localparam logic [7:0]  OFS_ERR_ADDR = 8'h0C;

    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} raeu_size_e;

    typedef enum logic [2:0] {
        SP_NORMAL = 3'h0,
        SP_PURGE  = 3'h1,
        SP_ADDR   = 3'h2,
        SP_DATA   = 3'h3,
        SP_PERIPH = 3'h4,
        SP_SDMODE = 3'h5
    } raeu_space_e;

    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        pcrel;
        logic        tas;
        logic        sdmode_wr;
        raeu_size_e  size;
        raeu_space_e space;
        logic [31:0] addr;
    } raeu_acc_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_HOLD  = 4'h1,
        ST_RPC   = 4'h3,
        ST_RSP   = 4'h2,
        ST_LOAD  = 4'h6,
        ST_AEW   = 4'h7,
        ST_PSR   = 4'h5,
        ST_PPC   = 4'h4,
        ST_VEC   = 4'hC,
        ST_JMP   = 4'hD,
        ST_MWAIT = 4'hF
    } raeu_state_e;

endpackage

// file: logic/raeu_addr_check.sv
// Address error classifier for one bus master access
`timescale 1ns/1ps
module raeu_addr_check (
    input  wire raeu_pkg::raeu_acc_s i_acc,
    output wire logic                o_err
);
    wire logic [23:0] page      = i_acc.addr[31:8];
    wire logic        periph    = (i_acc.space == raeu_pkg::SP_PERIPH);
    wire logic        pg_fe     = (page == raeu_pkg::PER_PG_FE);
    wire logic        pg_low    = (page >= raeu_pkg::PER_PG_00_LO)
                                && (page <= raeu_pkg::PER_PG_00_HI);
    wire logic        pg_ff     = (page == raeu_pkg::PER_PG_FF);
    wire logic        is_byte   = (i_acc.size == raeu_pkg::SZ_BYTE);
    wire logic        is_word   = (i_acc.size == raeu_pkg::SZ_WORD);
    wire logic        is_long   = (i_acc.size == raeu_pkg::SZ_LONG);
    wire logic        special   = (i_acc.space == raeu_pkg::SP_PURGE)
                                || (i_acc.space == raeu_pkg::SP_ADDR)
                                || periph
                                || (i_acc.space == raeu_pkg::SP_SDMODE);
    wire logic        e_fetch   = i_acc.fetch && (i_acc.addr[0] || periph);
    wire logic        e_word    = !i_acc.fetch && is_word && i_acc.addr[0];
    wire logic        e_long    = !i_acc.fetch && is_long && (i_acc.addr[1:0] != 2'h0);
    wire logic        e_pcrel   = i_acc.pcrel && special;
    wire logic        e_tas     = i_acc.tas && (special || i_acc.space == raeu_pkg::SP_DATA);
    // FC page adds no size restriction; alignment and the fetch, PC-relative and TAS rules apply
    wire logic        e_per_fe  = !i_acc.fetch && periph && pg_fe && is_long;
    wire logic        e_per_bt  = !i_acc.fetch && periph && (pg_low || pg_ff) && is_byte;

    assign o_err = i_acc.valid && !i_acc.sdmode_wr
                && (e_fetch || e_word || e_long || e_pcrel || e_tas || e_per_fe || e_per_bt);
endmodule

// file: logic/raeu_core.sv
// Reset sequencing and address error exception handling
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module raeu_core #(
    parameter int N_MAST = raeu_pkg::N_MAST
) (
    input  wire  logic                            i_clk,
    input  wire  logic                            i_rst_n,
    input  wire  logic                            i_chip_init_pin_n,
    input  wire  logic                            i_nmi_pin,
    input  wire  raeu_pkg::raeu_acc_s [N_MAST-1:0] i_acc,
    input  wire  logic                            i_bus_busy,
    input  wire  logic                            i_insn_done,
    input  wire  logic [31:0]                     i_status_word,
    input  wire  logic [31:0]                     i_next_pc,
    input  wire  logic [31:0]                     i_sp,
    input  wire  logic                            i_mem_ack,
    input  wire  logic [31:0]                     i_mem_rdata,
    input  wire  logic [7:0]                      i_reg_addr,
    input  wire  logic [31:0]                     i_reg_wdata,
    input  wire  logic                            i_reg_wr,
    input  wire  logic                            i_reg_rd,
    output logic [31:0]                           o_reg_rdata,
    output wire  logic                            o_mem_req,
    output wire  logic                            o_mem_wr,
    output logic [31:0]                           o_mem_addr,
    output logic [31:0]                           o_mem_wdata,
    output wire  logic                            o_cpu_init,
    output wire  logic                            o_periph_init,
    output wire  logic                            o_keep_unit_init,
    output wire  logic                            o_exc_busy,
    output wire  logic                            o_load,
    output wire  logic                            o_jump,
    output logic [31:0]                           o_pc,
    output logic [31:0]                           o_sp,
    output logic [31:0]                           o_vector_base,
    output logic [3:0]                            o_int_mask_level,
    output logic [1:0]                            o_dma_addr_err_flag
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire logic [1:0] pin_raw = {i_nmi_pin, i_chip_init_pin_n};
    logic      [1:0] pin_lvl_r;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            logic [raeu_pkg::SYNC_STAGES-1:0] sync_r;
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync_r       <= '1;
                    pin_lvl_r[g] <= 1'b1;
                end else begin
                    sync_r <= {sync_r[raeu_pkg::SYNC_STAGES-2:0], pin_raw[g]};
                    // Level only moves once the last two stages agree
                    if (sync_r[1] == sync_r[2]) begin
                        pin_lvl_r[g] <= sync_r[2];
                    end
                end
            end
        end
    endgenerate
    wire logic init_low = !pin_lvl_r[0];
    wire logic nmi_high = pin_lvl_r[1];

    // ------------------------------------------------------------
    // Address checks per master
    // ------------------------------------------------------------
    logic [N_MAST-1:0] err;
    generate
        for (g = 0; g < N_MAST; g++) begin : g_chk
            raeu_addr_check u_chk (
                .i_acc (i_acc[g]),
                .o_err (err[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    raeu_pkg::raeu_state_e state_r;
    raeu_pkg::raeu_state_e state_nxt;
    logic        por_r;
    logic        por_nxt;
    logic        cpu_pend_r;
    logic        dma_pend_r;
    logic [1:0]  dma_flag_r;
    logic [7:0]  vec_r;
    logic [7:0]  vec_nxt;
    logic [31:0] addr_nxt;
    logic [31:0] wdata_nxt;
    logic [31:0] err_addr_r;

    wire logic in_rst   = (state_r == raeu_pkg::ST_HOLD) || (state_r == raeu_pkg::ST_MWAIT);
    wire logic rst_take = init_low && !in_rst;
    wire logic ae_take  = (state_r == raeu_pkg::ST_IDLE) && !init_low && (cpu_pend_r || dma_pend_r);
    wire logic done_ok  = !i_bus_busy && i_insn_done;
    wire logic cpu_set  = err[0] && !in_rst;
    wire logic [1:0] dma_set = err[2:1] & {2{!in_rst}};

    wire logic sel_vb   = (i_reg_addr == raeu_pkg::OFS_VBASE);
    wire logic sel_st   = (i_reg_addr == raeu_pkg::OFS_STATUS);
    wire logic sel_dma  = (i_reg_addr == raeu_pkg::OFS_DMA_ERR);
    wire logic sel_ea   = (i_reg_addr == raeu_pkg::OFS_ERR_ADDR);
    wire logic [1:0] dma_clr = {2{i_reg_wr && sel_dma}} & i_reg_wdata[1:0];

    wire logic [31:0] vec_ofs = {24'h00_0000, vec_r} * raeu_pkg::VEC_SCALE;
    wire logic [31:0] reg_rd_nxt =
        sel_vb  ? o_vector_base :
        sel_st  ? {24'h00_0000, state_r, por_r, 1'b0, dma_pend_r, cpu_pend_r} :
        sel_dma ? {30'h0000_0000, dma_flag_r} :
        sel_ea  ? err_addr_r : 32'h0000_0000;

    assign o_mem_req = (state_r == raeu_pkg::ST_RPC) || (state_r == raeu_pkg::ST_RSP)
                    || (state_r == raeu_pkg::ST_PSR) || (state_r == raeu_pkg::ST_PPC)
                    || (state_r == raeu_pkg::ST_VEC);
    assign o_mem_wr  = (state_r == raeu_pkg::ST_PSR) || (state_r == raeu_pkg::ST_PPC);
    assign o_cpu_init       = (state_r == raeu_pkg::ST_HOLD);
    assign o_periph_init    = (state_r == raeu_pkg::ST_HOLD);
    // Bus, break, pin and frequency units keep state on manual reset
    assign o_keep_unit_init = (state_r == raeu_pkg::ST_HOLD) && por_r;
    assign o_exc_busy = (state_r != raeu_pkg::ST_IDLE) || init_low;
    assign o_load = (state_r == raeu_pkg::ST_LOAD);
    assign o_jump = (state_r == raeu_pkg::ST_JMP);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        por_nxt   = por_r;
        vec_nxt   = vec_r;
        addr_nxt  = o_mem_addr;
        wdata_nxt = o_mem_wdata;
        if (rst_take) begin
            por_nxt = nmi_high;
            // A manual reset never cuts a bus cycle short
            state_nxt = (!nmi_high && i_bus_busy) ? raeu_pkg::ST_MWAIT
                                                  : raeu_pkg::ST_HOLD;
        end else begin
            case (state_r)
                raeu_pkg::ST_MWAIT: begin
                    if (!i_bus_busy) begin
                        state_nxt = raeu_pkg::ST_HOLD;
                    end
                end
                raeu_pkg::ST_HOLD: begin
                    if (!init_low) begin
                        vec_nxt   = por_r ? raeu_pkg::VEC_POR_PC : raeu_pkg::VEC_MAN_PC;
                        addr_nxt  = {24'h00_0000, vec_nxt} * raeu_pkg::VEC_SCALE;
                        state_nxt = raeu_pkg::ST_RPC;
                    end
                end
                raeu_pkg::ST_RPC: begin
                    if (i_mem_ack) begin
                        vec_nxt   = por_r ? raeu_pkg::VEC_POR_SP : raeu_pkg::VEC_MAN_SP;
                        addr_nxt  = {24'h00_0000, vec_nxt} * raeu_pkg::VEC_SCALE;
                        state_nxt = raeu_pkg::ST_RSP;
                    end
                end
                raeu_pkg::ST_RSP: begin
                    if (i_mem_ack) begin
                        state_nxt = raeu_pkg::ST_LOAD;
                    end
                end
                raeu_pkg::ST_LOAD: begin
                    state_nxt = raeu_pkg::ST_IDLE;
                end
                raeu_pkg::ST_IDLE: begin
                    if (ae_take) begin
                        // CPU error is served ahead of a DMA error
                        vec_nxt = cpu_pend_r ? raeu_pkg::VEC_CPU_AE
                                             : raeu_pkg::VEC_DMA_AE;
                        state_nxt = raeu_pkg::ST_AEW;
                    end
                end
                raeu_pkg::ST_AEW: begin
                    if (done_ok) begin
                        addr_nxt  = i_sp - raeu_pkg::STACK_STEP;
                        wdata_nxt = i_status_word;
                        state_nxt = raeu_pkg::ST_PSR;
                    end
                end
                raeu_pkg::ST_PSR: begin
                    if (i_mem_ack) begin
                        addr_nxt  = o_mem_addr - raeu_pkg::STACK_STEP;
                        wdata_nxt = i_next_pc;
                        state_nxt = raeu_pkg::ST_PPC;
                    end
                end
                raeu_pkg::ST_PPC: begin
                    if (i_mem_ack) begin
                        addr_nxt  = o_vector_base + vec_ofs;
                        state_nxt = raeu_pkg::ST_VEC;
                    end
                end
                raeu_pkg::ST_VEC: begin
                    if (i_mem_ack) begin
                        state_nxt = raeu_pkg::ST_JMP;
                    end
                end
                raeu_pkg::ST_JMP: begin
                    state_nxt = raeu_pkg::ST_IDLE;
                end
                default: begin
                    state_nxt = raeu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r     <= raeu_pkg::ST_IDLE;
            por_r       <= 1'b1;
            vec_r       <= 8'h00;
            o_mem_addr  <= 32'h0000_0000;
            o_mem_wdata <= 32'h0000_0000;
            o_reg_rdata <= 32'h0000_0000;
        end else begin
            state_r     <= state_nxt;
            por_r       <= por_nxt;
            vec_r       <= vec_nxt;
            o_mem_addr  <= addr_nxt;
            o_mem_wdata <= wdata_nxt;
            o_reg_rdata <= i_reg_rd ? reg_rd_nxt : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Loaded values and error flags
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pc             <= 32'h0000_0000;
            o_sp             <= 32'h0000_0000;
            o_vector_base    <= raeu_pkg::VBASE_RST;
            o_int_mask_level <= raeu_pkg::MASK_RST;
        end else begin
            if ((state_r == raeu_pkg::ST_RPC || state_r == raeu_pkg::ST_VEC) && i_mem_ack) begin
                o_pc <= i_mem_rdata;
            end
            if (state_r == raeu_pkg::ST_RSP && i_mem_ack) begin
                o_sp <= i_mem_rdata;
            end else if (state_r == raeu_pkg::ST_PPC && i_mem_ack) begin
                o_sp <= o_mem_addr;
            end
            // Reset load wins over a software write in the same cycle
            if (state_r == raeu_pkg::ST_LOAD) begin
                o_vector_base    <= raeu_pkg::VBASE_RST;
                o_int_mask_level <= raeu_pkg::MASK_RST;
            end else if (i_reg_wr && sel_vb) begin
                o_vector_base <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_pend_r          <= 1'b0;
            dma_pend_r          <= 1'b0;
            dma_flag_r          <= 2'h0;
            err_addr_r          <= 32'h0000_0000;
        end else begin
            // Reset discards pending errors; otherwise a new error beats the take
            if (init_low || in_rst) begin
                cpu_pend_r <= 1'b0;
                dma_pend_r <= 1'b0;
            end else begin
                cpu_pend_r <= cpu_set || (cpu_pend_r && !(ae_take && cpu_pend_r));
                dma_pend_r <= (|dma_set)
                           || (dma_pend_r && !(ae_take && !cpu_pend_r));
            end
            dma_flag_r <= dma_set | (dma_flag_r & ~dma_clr);
            if (cpu_set) begin
                err_addr_r <= i_acc[0].addr;
            end else if (dma_set[0]) begin
                err_addr_r <= i_acc[1].addr;
            end else if (dma_set[1]) begin
                err_addr_r <= i_acc[2].addr;
            end
        end
    end
    assign o_dma_addr_err_flag = dma_flag_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_rst_fetch;
        (state_r == raeu_pkg::ST_RPC && i_mem_ack && !init_low) ##1 (state_r == raeu_pkg::ST_RSP);
    endsequence
    sequence s_push;
        (state_r == raeu_pkg::ST_PSR && i_mem_ack && !init_low) ##1 (state_r == raeu_pkg::ST_PPC);
    endsequence

    property p_por;
        @(posedge i_clk) disable iff (!i_rst_n)
        (rst_take && nmi_high) |=> (state_r == raeu_pkg::ST_HOLD && por_r && o_keep_unit_init);
    endproperty
    a_por: assert property (p_por) else $error("power-on reset not entered");

    property p_man;
        @(posedge i_clk) disable iff (!i_rst_n)
        (rst_take && !nmi_high && !i_bus_busy) |=> (state_r == raeu_pkg::ST_HOLD && !por_r);
    endproperty
    a_man: assert property (p_man) else $error("manual reset not entered");

    property p_keep;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_r == raeu_pkg::ST_HOLD) |-> (o_cpu_init && o_periph_init && (o_keep_unit_init == por_r));
    endproperty
    a_keep: assert property (p_keep) else $error("init outputs wrong in reset");

    property p_release;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_r == raeu_pkg::ST_HOLD && !init_low) |=> (state_r == raeu_pkg::ST_RPC
            && o_mem_addr == (por_r ? 32'h0000_0000 : 32'h0000_0008));
    endproperty
    a_release: assert property (p_release) else $error("reset release not handled");

    property p_order;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_rst_fetch |-> (o_pc == $past(i_mem_rdata) && o_mem_req && !o_mem_wr);
    endproperty
    a_order: assert property (p_order) else $error("reset fetch order wrong");

    property p_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_load |=> (o_vector_base == 32'h0000_0000 && o_int_mask_level == 4'hF);
    endproperty
    a_clear: assert property (p_clear) else $error("reset did not clear base and mask");

    property p_noabort;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_r == raeu_pkg::ST_MWAIT && i_bus_busy) |=> (state_r == raeu_pkg::ST_MWAIT);
    endproperty
    a_noabort: assert property (p_noabort) else $error("manual reset cut a bus cycle");

    property p_prio;
        @(posedge i_clk) disable iff (!i_rst_n)
        init_low |=> (in_rst && !o_jump && !o_mem_req);
    endproperty
    a_prio: assert property (p_prio) else $error("reset did not take priority");

    property p_wait;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_r == raeu_pkg::ST_AEW && !done_ok && !init_low) |=> (state_r == raeu_pkg::ST_AEW);
    endproperty
    a_wait: assert property (p_wait) else $error("error handling started early");

    property p_push;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_push |-> (o_mem_wr && o_mem_addr == $past(o_mem_addr) - 32'h0000_0004);
    endproperty
    a_push: assert property (p_push) else $error("stack push order wrong");

    property p_vec;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_r == raeu_pkg::ST_VEC) |-> (o_mem_addr == o_vector_base + {22'h00_0000, vec_r, 2'h0}
            && (vec_r == 8'h09 || vec_r == 8'h0A));
    endproperty
    a_vec: assert property (p_vec) else $error("vector entry address wrong");

    property p_fetch_err;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_acc[0].valid && i_acc[0].fetch && i_acc[0].addr[0] && !i_acc[0].sdmode_wr
            && !init_low && !in_rst) |=> cpu_pend_r;
    endproperty
    a_fetch_err: assert property (p_fetch_err) else $error("odd fetch not flagged");
endmodule

// file: test/raeu_mem_model.sv
// Memory model answering vector fetches and stack pushes
`timescale 1ns/1ps
module raeu_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    output logic             o_ack,
    output logic [31:0]      o_rdata
);
    logic [1:0] wait_r;
    // Slow answer when address bit 2 is set, prompt otherwise
    always_ff @(posedge i_clk) begin
        o_ack  <= i_req && !o_ack && (wait_r == {1'b0, i_addr[2]});
        wait_r <= (i_req && !o_ack) ? wait_r + 2'h1 : 2'h0;
    end
    // Data outside the answer cycle is scrambled, never the last value
    assign o_rdata = o_ack ? ~i_addr : {i_addr[15:0], i_addr[31:16]};
endmodule

// file: test/raeu_core_tb.sv
// Self-checking bench for the reset and address error unit
`timescale 1ns/1ps
module raeu_core_tb;
    logic i_clk = 1'b0, i_rst_n = 1'b0, pin_n = 1'b1, nmi = 1'b1, busy = 1'b0, done = 1'b1;
    logic wr = 1'b0, rd = 1'b0, ack, load, jump, req, cinit, pinit, kinit, ebusy, mwr;
    logic [7:0] ra = 8'h00;
    logic [31:0] wd = 32'h0, sw = 32'h0, sp = 32'h0, vb, rdat, rdata, maddr, pc, spo, vbo, mwd;
    logic [63:0] pushed = '0;
    logic [3:0] mask;
    logic [1:0] flag;
    raeu_pkg::raeu_acc_s [2:0] acc = '0;
    raeu_pkg::raeu_acc_s ta[10];
    int tm[10] = '{0, 0, 1, 2, 0, 0, 0, 0, 1, 1};
    logic te[10] = '{1, 1, 1, 1, 1, 1, 0, 1, 1, 0};
    integer seed = 68, bad_count = 0, cmp_count = 0;
    always #5 i_clk = ~i_clk;
    // Record every completed stack push, oldest in the upper half
    always @(posedge i_clk) if (req && ack && mwr) pushed <= {pushed[31:0], mwd};
    raeu_mem_model mem (.i_clk(i_clk), .i_req(req), .i_addr(maddr), .o_ack(ack), .o_rdata(rdat));
    raeu_core uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_chip_init_pin_n(pin_n), .i_nmi_pin(nmi),
        .i_acc(acc), .i_bus_busy(busy), .i_insn_done(done), .i_status_word(sw), .i_next_pc(~sw),
        .i_sp(sp), .i_mem_ack(ack), .i_mem_rdata(rdat), .i_reg_addr(ra), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_mem_req(req), .o_mem_wr(mwr),
        .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_cpu_init(cinit), .o_periph_init(pinit),
        .o_keep_unit_init(kinit), .o_exc_busy(ebusy), .o_load(load), .o_jump(jump), .o_pc(pc),
        .o_sp(spo), .o_vector_base(vbo), .o_int_mask_level(mask), .o_dma_addr_err_flag(flag));
    function automatic raeu_pkg::raeu_acc_s mk(input logic [3:0] fl, input logic [4:0] ss,
                                               input logic [31:0] a);
        mk = {1'b1, fl, ss, a};
    endfunction
    function automatic logic [31:0] entry(input int m);
        entry = vb + 32'h4 * ((m == 0) ? 32'h9 : 32'hA);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(input logic j);
        for (int i = 0; i < 300 && (j ? jump : load) !== 1'b1; i++) @(posedge i_clk) #1;
        chk(j ? jump : load, 1'b1);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk) begin ra <= a; wd <= d; wr <= 1'b1; end
        @(posedge i_clk) wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk) begin ra <= a; rd <= 1'b1; end
        @(posedge i_clk) rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic do_reset(input logic por);
        @(posedge i_clk) begin nmi <= por; busy <= !por; end
        @(posedge i_clk) pin_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        #1 chk(cinit, por);
        @(posedge i_clk) busy <= 1'b0;
        repeat (15) @(posedge i_clk);
        #1 chk(pinit, 1'b1);
        chk(kinit, por);
        @(posedge i_clk) pin_n <= 1'b1;
        wait_hi(1'b0);
        chk(pc, por ? 32'hFFFF_FFFF : 32'hFFFF_FFF7);
        chk(spo, por ? 32'hFFFF_FFFB : 32'hFFFF_FFF3);
        @(posedge i_clk) #1 chk(vbo, 32'h0);
        chk(mask, 4'hF);
    endtask
    task automatic run_case(input int m, input raeu_pkg::raeu_acc_s a, input logic err);
        vb = $random(seed) & 32'h0000_FFF0;
        reg_wr(8'h00, vb);
        @(posedge i_clk) begin
            acc[m] <= a;
            done   <= 1'b0;
            sp     <= $random(seed) & 32'hFFFF_FFFC;
            sw     <= $random(seed);
        end
        @(posedge i_clk) acc[m] <= '0;
        repeat (6) @(posedge i_clk);
        #1 chk(req, 1'b0);
        @(posedge i_clk) done <= 1'b1;
        if (err) begin
            wait_hi(1'b1);
            chk(pc, ~entry(m));
            chk(spo, sp - 32'h8);
            chk(pushed[63:32], sw);
            chk(pushed[31:0], ~sw);
        end else #1 chk(ebusy, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        ta[0] = mk(4'h8, 5'h08, $random(seed) | 32'h1);
        ta[1] = mk(4'h8, 5'h0C, 32'hFFFF_FC00);
        ta[2] = mk(4'h0, 5'h08, 32'h0000_2001);
        ta[3] = mk(4'h0, 5'h10, 32'h0000_2002);
        ta[4] = mk(4'h4, 5'h11, 32'h4000_0000);
        ta[5] = mk(4'h2, 5'h03, 32'hC000_0000);
        ta[6] = mk(4'h0, 5'h04, 32'hFFFF_FC01);
        ta[7] = mk(4'h0, 5'h14, 32'hFFFF_FE00);
        ta[8] = mk(4'h0, 5'h04, 32'hFFFF_FF03);
        ta[9] = mk(4'h1, 5'h0D, 32'hFFFF_8001);
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        do_reset(1'b1);
        reg_wr(8'h00, 32'h0000_1230);
        reg_rd(8'h00, 32'h0000_1230);
        reg_rd(8'h10, 32'h0);
        do_reset(1'b0);
        for (int k = 0; k < 10; k++) run_case(tm[k], ta[k], te[k]);
        reg_rd(8'h04, 32'h0);
        reg_rd(8'h0C, 32'hFFFF_FF03);
        reg_rd(8'h08, 32'h3);
        chk(flag, 32'h3);
        reg_wr(8'h08, 32'h3);
        reg_rd(8'h08, 32'h0);
        chk(flag, 32'h0);
        tally_and_finish();
    end
    initial begin
        #300000;
        bad_count++;
        tally_and_finish();
    end
endmodule
